// ### hw/tsc_pkg.sv
package tsc_pkg;

	localparam int NTHR = 2;
	localparam int PA_W = 32;
	localparam int LINE_AW = 26;
	localparam int VPN_W = 20;
	localparam int PPN_W = 20;
	localparam int RA_W = 4;
	localparam int RD_W = 32;

	// register offsets
	localparam logic [RA_W-1:0] REG_T0_CTRL = 4'h0;
	localparam logic [RA_W-1:0] REG_T1_CTRL = 4'h4;
	localparam logic [RA_W-1:0] REG_STATUS = 4'h8;

	// synchronised pin positions
	localparam int NPINS = 6;
	localparam int PIN_STOP = 0;
	localparam int PIN_AMASK = 1;
	localparam int PIN_IRQ0 = 2;
	localparam int PIN_IRQ1 = 3;
	localparam int PIN_CAT = 4;
	localparam int PIN_TRIP = 5;
	// active-low pins idle high
	localparam logic [NPINS-1:0] PINS_RST = 6'h03;

	localparam int DUTY_W = 3;
	localparam logic [DUTY_W-1:0] DUTY_OFF = 3'h0;
	localparam logic [DUTY_W-1:0] AUTO_DUTY = 3'h4;
	localparam logic [PA_W-1:0] A20_CLR_MASK = 32'hFFEF_FFFF;

	typedef struct packed {
		logic irq1_mask;
		logic irq0_mask;
		logic [DUTY_W-1:0] duty;
		logic mod_en;
		logic cache_disable_flag;
	} tsc_thr_ctrl_t;
	localparam int CTRL_W = $bits(tsc_thr_ctrl_t);
	localparam tsc_thr_ctrl_t CTRL_RST = 7'h00;

	typedef struct packed {
		logic [DUTY_W-1:0] eff_duty;
		logic cache_disabled;
		logic addr_mask_active;
		logic auto_trip;
		logic cat_halt;
		logic stop_grant;
		logic maint_owner;
		logic maint_busy;
	} tsc_status_t;
	localparam int STAT_W = $bits(tsc_status_t);

	typedef enum logic [1:0] {
		MOP_WRITEBACK_INVALIDATE_ALL = 2'b00,
		MOP_INVALIDATE_ALL_NO_WRITEBACK = 2'b01,
		MOP_LINE_FLUSH = 2'b10
	} tsc_maint_op_t;

	typedef enum logic [1:0] {
		CK_WRITEBACK = 2'b00,
		CK_INVALIDATE = 2'b01,
		CK_WB_INV_LINE = 2'b10
	} tsc_cache_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WB = 3'b001,
		ST_INV = 3'b010,
		ST_LINE = 3'b011,
		ST_BCAST = 3'b100
	} tsc_maint_st_t;

	typedef enum logic [1:0] {
		TINV_PAGE_BASE = 2'b00,
		TINV_PAGING_FEATURE = 2'b01,
		TINV_SINGLE_PAGE = 2'b10
	} tsc_tinv_kind_t;

	typedef struct packed {
		logic valid;
		tsc_maint_op_t op;
		logic [LINE_AW-1:0] line;
	} tsc_maint_req_t;

	typedef struct packed {
		tsc_cache_kind_t kind;
		logic [LINE_AW-1:0] line;
	} tsc_cache_cmd_t;

	typedef struct packed {
		logic valid;
		tsc_tinv_kind_t kind;
		logic [VPN_W-1:0] vpn;
	} tsc_tlb_inv_t;

	typedef struct packed {
		logic valid;
		logic instr;
		logic [VPN_W-1:0] vpn;
	} tsc_tlb_lkp_t;

	typedef struct packed {
		logic valid;
		logic tid;
		logic instr;
		logic global_pg;
		logic [VPN_W-1:0] vpn;
		logic [PPN_W-1:0] ppn;
	} tsc_tlb_entry_t;

	typedef struct packed {
		logic valid;
		logic [PA_W-1:0] addr;
	} tsc_mem_req_t;

endpackage : tsc_pkg

// ### hw/tsc_shared_ctrl.sv
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// - whole flush writes back all, then invalidates
// - both threads stalled until whole flush done
// - broadcast bus cycle per whole-hierarchy operation
// - invalidate-all discards data, stalls both threads
// - line flush writes back, invalidates, broadcasts
// - maintenance acts on the one shared hierarchy
// - cache disabled when either thread flag set
// - data translations shared, instruction option
// - entries tagged with creating thread, lookups check
// - global translations still carry the thread tag
// - invalidation flushes only the issuing thread entries
// - catastrophic trip halts core, both threads stop
// - automatic trip modulates the shared core clock
// - per-thread modulation, highest duty wins
// - stop clock halts execution, snoops continue
// - stop-grant stops both threads, no interrupts
// - shared interrupt pins, per-thread masking
// - address mask forces bit 20 low
// - address mask applies to both threads
module tsc_shared_ctrl
	import tsc_pkg::*;
#(
	parameter int SETS = 64,
	parameter int TLB_N = 16,
	parameter bit ITLB_REPLICATED = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [RA_W-1:0] reg_addr_in,
	input wire logic [RD_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [RD_W-1:0] reg_rdata_out,
	input wire logic stop_clock_in_n,
	input wire logic addr_bit_mask_in_n,
	input wire logic local_irq_in0,
	input wire logic local_irq_in1,
	input wire logic cat_trip_in,
	input wire logic therm_trip_in,
	input wire tsc_maint_req_t [NTHR-1:0] maint_req_in,
	output logic [NTHR-1:0] maint_done_out,
	output logic cache_cmd_valid_out,
	output tsc_cache_cmd_t cache_cmd_out,
	input wire logic cache_cmd_ready_in,
	output logic bcast_valid_out,
	output tsc_maint_op_t bcast_kind_out,
	input wire logic bcast_ready_in,
	output logic cache_disable_out,
	output logic [NTHR-1:0] thread_stall_out,
	output logic core_clk_run_out,
	output logic stop_grant_out,
	output logic snoop_enable_out,
	output logic [NTHR-1:0][1:0] thread_irq_out,
	input wire tsc_tlb_entry_t tlb_fill_in,
	input wire tsc_tlb_lkp_t [NTHR-1:0] tlb_lkp_in,
	input wire tsc_tlb_inv_t [NTHR-1:0] tlb_inv_in,
	output logic [NTHR-1:0] tlb_hit_out,
	output logic [NTHR-1:0][PPN_W-1:0] tlb_ppn_out,
	output logic [NTHR-1:0] tlb_inv_done_out,
	input wire tsc_mem_req_t mem_req_in,
	output tsc_mem_req_t mem_req_out
);

	localparam int IDX_W = $clog2(TLB_N);
	localparam logic [LINE_AW-1:0] SET_LAST = LINE_AW'(SETS - 1);

	generate
		if (SETS < 1 || SETS > 2 ** 20) begin : g_bad_sets
			$error("SETS out of range");
		end
		if (TLB_N < 4 || (1 << IDX_W) != TLB_N) begin : g_bad_tlb
			$error("TLB_N must be a power of two, at least 4");
		end
	endgenerate

	// pin synchronisers
	logic [NPINS-1:0] pin_raw;
	logic [NPINS-1:0] meta_q;
	logic [NPINS-1:0] sync_q;

	assign pin_raw[PIN_STOP] = stop_clock_in_n;
	assign pin_raw[PIN_AMASK] = addr_bit_mask_in_n;
	assign pin_raw[PIN_IRQ0] = local_irq_in0;
	assign pin_raw[PIN_IRQ1] = local_irq_in1;
	assign pin_raw[PIN_CAT] = cat_trip_in;
	assign pin_raw[PIN_TRIP] = therm_trip_in;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta_q <= PINS_RST;
			sync_q <= PINS_RST;
		end else begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
		end
	end

	wire stop_grant = ~sync_q[PIN_STOP];
	wire addr_mask_on = ~sync_q[PIN_AMASK];
	wire auto_trip = sync_q[PIN_TRIP];

	logic cat_halt_q;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cat_halt_q <= 1'b0;
		end else if (sync_q[PIN_CAT]) begin
			cat_halt_q <= 1'b1;
		end
	end

	// per-thread control registers
	tsc_thr_ctrl_t [NTHR-1:0] ctrl_q;
	tsc_status_t status;
	logic [RD_W-1:0] rdata_q;

	wire wr_t0 = reg_wr_in && (reg_addr_in == REG_T0_CTRL);
	wire wr_t1 = reg_wr_in && (reg_addr_in == REG_T1_CTRL);
	wire sel_t0 = reg_addr_in == REG_T0_CTRL;
	wire sel_t1 = reg_addr_in == REG_T1_CTRL;
	wire sel_st = reg_addr_in == REG_STATUS;
	wire [RD_W-1:0] rd_mux = sel_t0 ? RD_W'(ctrl_q[0]) :
		sel_t1 ? RD_W'(ctrl_q[1]) :
		sel_st ? RD_W'(status) : '0;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ctrl_q <= {CTRL_RST, CTRL_RST};
			rdata_q <= '0;
		end else begin
			if (wr_t0) begin
				ctrl_q[0] <= reg_wdata_in[CTRL_W-1:0];
			end
			if (wr_t1) begin
				ctrl_q[1] <= reg_wdata_in[CTRL_W-1:0];
			end
			rdata_q <= reg_rd_in ? rd_mux : '0;
		end
	end
	assign reg_rdata_out = rdata_q;

	// either thread's flag disables the shared cache
	assign cache_disable_out = ctrl_q[0].cache_disable_flag |
		ctrl_q[1].cache_disable_flag;

	// clock modulation
	logic [DUTY_W-1:0] phase_q;
	logic run_q;
	wire [DUTY_W-1:0] sw_duty0 = ctrl_q[0].mod_en ? ctrl_q[0].duty : DUTY_OFF;
	wire [DUTY_W-1:0] sw_duty1 = ctrl_q[1].mod_en ? ctrl_q[1].duty : DUTY_OFF;
	wire [DUTY_W-1:0] sw_max = (sw_duty0 > sw_duty1) ?
		sw_duty0 : sw_duty1;
	wire [DUTY_W-1:0] eff_duty = auto_trip ? AUTO_DUTY : sw_max;
	wire run_d = ~cat_halt_q &&
		((eff_duty == DUTY_OFF) || (phase_q < eff_duty));

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			phase_q <= '0;
			run_q <= 1'b0;
		end else begin
			phase_q <= phase_q + 1'b1;
			run_q <= run_d;
		end
	end
	assign core_clk_run_out = run_q;

	// cache maintenance sequencer
	tsc_maint_st_t st_q;
	tsc_maint_st_t st_d;
	tsc_cache_cmd_t cmd_q;
	tsc_cache_cmd_t cmd_d;
	tsc_maint_op_t op_q;
	logic owner_q;
	logic [NTHR-1:0] done_q;

	wire req0 = maint_req_in[0].valid && !done_q[0];
	wire req1 = maint_req_in[1].valid && !done_q[1];
	wire req_sel = req0 ? 1'b0 : 1'b1;
	wire grant = (st_q == ST_IDLE) && (req0 || req1);
	wire tsc_maint_req_t req_g = maint_req_in[req_sel];
	wire sweep = (st_q == ST_WB) || (st_q == ST_INV);
	wire step = sweep && cache_cmd_ready_in;
	wire at_last = cmd_q.line == SET_LAST;
	wire whole_busy = (st_q != ST_IDLE) && (op_q != MOP_LINE_FLUSH);

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (grant) begin
					if (req_g.op == MOP_LINE_FLUSH) begin
						st_d = ST_LINE;
					end else if (req_g.op == MOP_INVALIDATE_ALL_NO_WRITEBACK) begin
						st_d = ST_INV;
					end else begin
						st_d = ST_WB;
					end
				end
			end
			ST_WB: begin
				if (cache_cmd_ready_in && at_last) begin
					st_d = ST_INV;
				end
			end
			ST_INV: begin
				if (cache_cmd_ready_in && at_last) begin
					st_d = ST_BCAST;
				end
			end
			ST_LINE: begin
				if (cache_cmd_ready_in) begin
					st_d = ST_BCAST;
				end
			end
			ST_BCAST: begin
				if (bcast_ready_in) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_comb begin
		cmd_d = cmd_q;
		if (grant) begin
			cmd_d.line = '0;
			if (req_g.op == MOP_LINE_FLUSH) begin
				cmd_d.kind = CK_WB_INV_LINE;
				cmd_d.line = req_g.line;
			end else if (req_g.op == MOP_INVALIDATE_ALL_NO_WRITEBACK) begin
				cmd_d.kind = CK_INVALIDATE;
			end else begin
				cmd_d.kind = CK_WRITEBACK;
			end
		end else if (step) begin
			if (at_last) begin
				cmd_d.kind = CK_INVALIDATE;
				cmd_d.line = '0;
			end else begin
				cmd_d.line = cmd_q.line + 1'b1;
			end
		end
	end

	wire bcast_end = (st_q == ST_BCAST) && bcast_ready_in;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_q <= ST_IDLE;
			cmd_q <= '0;
			op_q <= MOP_WRITEBACK_INVALIDATE_ALL;
			owner_q <= 1'b0;
			done_q <= '0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			if (grant) begin
				op_q <= req_g.op;
				owner_q <= req_sel;
			end
			done_q[0] <= bcast_end && (owner_q == 1'b0);
			done_q[1] <= bcast_end && (owner_q == 1'b1);
		end
	end

	assign maint_done_out = done_q;
	assign cache_cmd_valid_out = sweep || (st_q == ST_LINE);
	assign cache_cmd_out = cmd_q;
	assign bcast_valid_out = st_q == ST_BCAST;
	assign bcast_kind_out = op_q;

	// thread stall, stop-grant and snoops
	wire stall_all = whole_busy || stop_grant || cat_halt_q;
	assign thread_stall_out = {NTHR{stall_all}};
	assign stop_grant_out = stop_grant;
	assign snoop_enable_out = 1'b1;

	// shared interrupt pins, masked per thread and in stop-grant
	logic [NTHR-1:0][1:0] irq_q;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			irq_q <= '0;
		end else begin
			for (int t = 0; t < NTHR; t++) begin
				irq_q[t][0] <= sync_q[PIN_IRQ0] && !ctrl_q[t].irq0_mask &&
					!stop_grant;
				irq_q[t][1] <= sync_q[PIN_IRQ1] && !ctrl_q[t].irq1_mask &&
					!stop_grant;
			end
		end
	end
	assign thread_irq_out = irq_q;

	// external memory address path
	tsc_mem_req_t mem_q;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			mem_q <= '0;
		end else begin
			mem_q.valid <= mem_req_in.valid;
			mem_q.addr <= addr_mask_on ? (mem_req_in.addr & A20_CLR_MASK) :
				mem_req_in.addr;
		end
	end
	assign mem_req_out = mem_q;

	// shared, thread-tagged translation buffer
	tsc_tlb_entry_t tlb_q [TLB_N];
	logic [IDX_W-1:0] vic_q;
	logic [TLB_N-1:0] kill;
	logic [NTHR-1:0][TLB_N-1:0] inv_hit;
	logic [NTHR-1:0][TLB_N-1:0] lk_hit;
	logic [NTHR-1:0][PPN_W-1:0] ppn_sel;
	logic [NTHR-1:0] hit_q;
	logic [NTHR-1:0][PPN_W-1:0] ppn_q;
	logic [NTHR-1:0] inv_done_q;

	// replicated option keeps each thread's instruction fills in its half
	wire [IDX_W-1:0] fill_idx = (ITLB_REPLICATED && tlb_fill_in.instr) ?
		{tlb_fill_in.tid, vic_q[IDX_W-2:0]} : vic_q;

	genvar e, t;
	generate
		for (e = 0; e < TLB_N; e++) begin : g_ent
			for (t = 0; t < NTHR; t++) begin : g_thr
				wire own = tlb_q[e].valid && (tlb_q[e].tid == 1'(t));
				assign inv_hit[t][e] = tlb_inv_in[t].valid && own &&
					((tlb_inv_in[t].kind == TINV_PAGING_FEATURE) ||
					(tlb_inv_in[t].kind == TINV_PAGE_BASE &&
					!tlb_q[e].global_pg) ||
					(tlb_inv_in[t].kind == TINV_SINGLE_PAGE &&
					tlb_q[e].vpn == tlb_inv_in[t].vpn));
				assign lk_hit[t][e] = tlb_lkp_in[t].valid && own &&
					(tlb_q[e].instr == tlb_lkp_in[t].instr) &&
					(tlb_q[e].vpn == tlb_lkp_in[t].vpn);
			end
			assign kill[e] = |{inv_hit[1][e], inv_hit[0][e]};
		end
	endgenerate

	always_comb begin
		ppn_sel = '0;
		for (int th = 0; th < NTHR; th++) begin
			for (int i = 0; i < TLB_N; i++) begin
				if (lk_hit[th][i]) begin
					ppn_sel[th] = ppn_sel[th] | tlb_q[i].ppn;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < TLB_N; i++) begin
				tlb_q[i] <= '0;
			end
			vic_q <= '0;
		end else begin
			for (int i = 0; i < TLB_N; i++) begin
				if (tlb_fill_in.valid && fill_idx == IDX_W'(i)) begin
					tlb_q[i] <= tlb_fill_in;
				end else if (kill[i]) begin
					tlb_q[i].valid <= 1'b0;
				end
			end
			if (tlb_fill_in.valid) begin
				vic_q <= vic_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			hit_q <= '0;
			ppn_q <= '0;
			inv_done_q <= '0;
		end else begin
			for (int th = 0; th < NTHR; th++) begin
				hit_q[th] <= |lk_hit[th];
				ppn_q[th] <= ppn_sel[th];
				inv_done_q[th] <= tlb_inv_in[th].valid;
			end
		end
	end
	assign tlb_hit_out = hit_q;
	assign tlb_ppn_out = ppn_q;
	assign tlb_inv_done_out = inv_done_q;

	// status word
	assign status.eff_duty = eff_duty;
	assign status.cache_disabled = cache_disable_out;
	assign status.addr_mask_active = addr_mask_on;
	assign status.auto_trip = auto_trip;
	assign status.cat_halt = cat_halt_q;
	assign status.stop_grant = stop_grant;
	assign status.maint_owner = owner_q;
	assign status.maint_busy = st_q != ST_IDLE;

endmodule : tsc_shared_ctrl

// ### tb/tsc_shared_ctrl_sva.sv
`timescale 1ns/1ps
module tsc_shared_ctrl_sva
	import tsc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic stop_clock_in_n,
	input wire logic addr_bit_mask_in_n,
	input wire logic [NTHR-1:0] maint_done_out,
	input wire logic cache_cmd_valid_out,
	input wire tsc_cache_cmd_t cache_cmd_out,
	input wire logic cache_cmd_ready_in,
	input wire logic bcast_valid_out,
	input wire tsc_maint_op_t bcast_kind_out,
	input wire logic bcast_ready_in,
	input wire logic [NTHR-1:0] thread_stall_out,
	input wire logic stop_grant_out,
	input wire logic snoop_enable_out,
	input wire tsc_tlb_inv_t [NTHR-1:0] tlb_inv_in,
	input wire logic [NTHR-1:0] tlb_inv_done_out,
	input wire tsc_mem_req_t mem_req_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_mask; !addr_bit_mask_in_n [*4]; endsequence
	sequence s_stop; !stop_clock_in_n [*3]; endsequence
	sequence s_bc_acc; bcast_valid_out && bcast_ready_in; endsequence
	a_cmd_hold: assert property (
		cache_cmd_valid_out && !cache_cmd_ready_in
		|=> cache_cmd_valid_out && $stable(cache_cmd_out))
		else $error("cache command changed before accept");
	a_bcast_hold: assert property (
		bcast_valid_out && !bcast_ready_in
		|=> bcast_valid_out && $stable(bcast_kind_out))
		else $error("broadcast changed before accept");
	a_done_cause: assert property (
		maint_done_out != 0 |-> $past(bcast_valid_out && bcast_ready_in))
		else $error("done without broadcast");
	a_done_after: assert property (
		s_bc_acc |=> $onehot(maint_done_out))
		else $error("done not one owner after broadcast");
	a_stall_same: assert property (
		thread_stall_out[0] == thread_stall_out[1] &&
		(!cache_cmd_valid_out || cache_cmd_out.kind == CK_WB_INV_LINE ||
		thread_stall_out[0]))
		else $error("threads not both stalled during sweep");
	a_addr_mask: assert property (
		s_mask |=> !mem_req_out.valid || !mem_req_out.addr[20])
		else $error("address bit 20 not masked");
	a_stop_halt: assert property (
		s_stop |=> thread_stall_out == 2'b11 && stop_grant_out
		&& snoop_enable_out)
		else $error("stop grant not entered");
	a_inv_exact: assert property (
		##1 tlb_inv_done_out
		== $past({tlb_inv_in[1].valid, tlb_inv_in[0].valid}))
		else $error("invalidate done mismatch");
endmodule : tsc_shared_ctrl_sva

bind tsc_shared_ctrl tsc_shared_ctrl_sva u_sva (.ref_clk_in, .rst_in,
	.stop_clock_in_n, .addr_bit_mask_in_n, .maint_done_out,
	.cache_cmd_valid_out, .cache_cmd_out, .cache_cmd_ready_in,
	.bcast_valid_out, .bcast_kind_out, .bcast_ready_in, .thread_stall_out,
	.stop_grant_out, .snoop_enable_out, .tlb_inv_in, .tlb_inv_done_out,
	.mem_req_out);

// ### tb/tsc_cache_agent.sv
`timescale 1ns/1ps
module tsc_cache_agent
	import tsc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic slow_in,
	input wire logic cmd_valid_in,
	input wire tsc_cache_cmd_t cmd_in,
	input wire logic bcast_valid_in,
	output logic cmd_ready_out,
	output logic bcast_ready_out
);
	logic [7:0] lfsr_q = 8'h5a;
	logic inv_seen_q = 1'b0;
	int n_wb = 0, n_inv = 0, n_line = 0, n_bc = 0, n_bad = 0;
	// slow mode stalls both handshakes at pseudo-random cycles
	assign cmd_ready_out = !slow_in || lfsr_q[0];
	assign bcast_ready_out = !slow_in || lfsr_q[3];
	always_ff @(posedge ref_clk_in) begin
		// the stall pattern restarts with every reset
		lfsr_q <= rst_in ? 8'h5a :
			{lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		if (cmd_valid_in && cmd_ready_out) begin
			case (cmd_in.kind)
				CK_WRITEBACK: begin
					n_wb <= n_wb + 1;
					// a write-back after the invalidate pass is an order fault
					if (inv_seen_q) n_bad <= n_bad + 1;
				end
				CK_INVALIDATE: begin
					n_inv <= n_inv + 1;
					inv_seen_q <= 1'b1;
				end
				default: n_line <= n_line + 1;
			endcase
		end
		if (bcast_valid_in && bcast_ready_out) begin
			n_bc <= n_bc + 1;
			inv_seen_q <= 1'b0;
		end
	end
endmodule : tsc_cache_agent

// ### tb/tb_two_thread_shared_cache_tlb_control.sv
`timescale 1ns/1ps
module tb_two_thread_shared_cache_tlb_control
	import tsc_pkg::*;
;
	localparam int SETS = 4;
	logic ref_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, slow = 0;
	logic [RA_W-1:0] reg_addr_in = '0;
	logic [RD_W-1:0] reg_wdata_in = '0, reg_rdata_out, r, a, b;
	logic stop_clock_in_n = 1, addr_bit_mask_in_n = 1, local_irq_in0 = 0;
	logic local_irq_in1 = 0, cat_trip_in = 0, therm_trip_in = 0;
	tsc_maint_req_t [NTHR-1:0] maint_req_in = '0;
	logic [NTHR-1:0] maint_done_out, thread_stall_out, tlb_hit_out;
	logic [NTHR-1:0] tlb_inv_done_out;
	logic cache_cmd_valid_out, cache_cmd_ready_in, bcast_valid_out;
	logic bcast_ready_in, cache_disable_out, core_clk_run_out;
	logic stop_grant_out, snoop_enable_out;
	tsc_cache_cmd_t cache_cmd_out;
	tsc_maint_op_t bcast_kind_out;
	logic [NTHR-1:0][1:0] thread_irq_out;
	tsc_tlb_entry_t tlb_fill_in = '0;
	tsc_tlb_lkp_t [NTHR-1:0] tlb_lkp_in = '0;
	tsc_tlb_inv_t [NTHR-1:0] tlb_inv_in = '0;
	logic [NTHR-1:0][PPN_W-1:0] tlb_ppn_out;
	tsc_mem_req_t mem_req_in = '0, mem_req_out;
	int error_cnt = 0, n_tests = 0, seed = 32'hfebd_4710, k;
	int ewb = 0, einv = 0, eline = 0, ebc = 0;
	logic [VPN_W-1:0] v;
	logic [PPN_W-1:0] p;

	tsc_shared_ctrl #(.SETS(SETS)) DUT (.*);
	tsc_cache_agent AG (.ref_clk_in, .rst_in, .slow_in(slow),
		.cmd_valid_in(cache_cmd_valid_out), .cmd_in(cache_cmd_out),
		.bcast_valid_in(bcast_valid_out), .cmd_ready_out(cache_cmd_ready_in),
		.bcast_ready_out(bcast_ready_in));

	initial begin
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task wr(input logic [RA_W-1:0] ad, input logic [RD_W-1:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= ad;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task rd(input logic [RA_W-1:0] ad, output logic [RD_W-1:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= ad;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : rd

	function automatic logic [2:0] edut(input logic [31:0] x, y);
		logic [2:0] dx, dy;
		dx = x[1] ? x[4:2] : 3'h0;
		dy = y[1] ? y[4:2] : 3'h0;
		return dx > dy ? dx : dy;
	endfunction : edut

	task look(input logic h);
		@(posedge ref_clk_in);
		tlb_lkp_in <= {2{1'b1, 1'b0, v}};
		@(posedge ref_clk_in);
		tlb_lkp_in <= '0;
		#1 chk(tlb_hit_out, {1'b0, h});
		if (h) chk(tlb_ppn_out[0], p);
	endtask : look

	task mop(input logic [1:0] m, input tsc_maint_op_t op);
		logic [1:0] got, first;
		logic st;
		got = 0;
		first = 0;
		st = 0;
		@(posedge ref_clk_in);
		for (int t = 0; t < 2; t++)
			maint_req_in[t] <= '{m[t], op, LINE_AW'($random(seed))};
		for (int i = 0; i < 400 && got != m; i++) begin
			@(posedge ref_clk_in);
			for (int t = 0; t < 2; t++)
				if (got[t]) maint_req_in[t].valid <= 1'b0;
			#1 st |= thread_stall_out[0];
			if (bcast_valid_out) chk(bcast_kind_out, op);
			if (first == 0) first = maint_done_out;
			got |= maint_done_out;
		end
		@(posedge ref_clk_in);
		maint_req_in <= '0;
		if (got != m) begin
			error_cnt++;
			complete_run;
		end
		chk(first, m == 2'b11 ? 2'b01 : m);
		chk(st, op != MOP_LINE_FLUSH);
		k = m[0] + m[1];
		ebc += k;
		if (op == MOP_WRITEBACK_INVALIDATE_ALL) ewb += k * SETS;
		if (op != MOP_LINE_FLUSH) einv += k * SETS;
		else eline += k;
		chk(AG.n_wb, ewb);
		chk(AG.n_inv, einv);
		chk(AG.n_line, eline);
		chk(AG.n_bc, ebc);
		chk(AG.n_bad, 0);
	endtask : mop

	initial begin
		repeat (4) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(4'hc, r);
		chk(r, 0);
		for (int i = 0; i < 6; i++) begin
			a = $random(seed);
			b = $random(seed);
			if (i == 0) b = a;
			wr(REG_T0_CTRL, a);
			wr(REG_T1_CTRL, b);
			rd(REG_T0_CTRL, r);
			chk(r, a & 32'h0000_007f);
			rd(REG_STATUS, r);
			chk(r[9:7], edut(a, b));
			chk(cache_disable_out, a[0] | b[0]);
		end
		v = $random(seed);
		p = $random(seed);
		@(posedge ref_clk_in);
		tlb_fill_in <= '{1'b1, 1'b0, 1'b0, 1'b1, v, p};
		@(posedge ref_clk_in);
		tlb_fill_in <= '0;
		look(1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk_in);
			tlb_inv_in[i == 0] <= '{1'b1, i == 0 ? TINV_PAGING_FEATURE :
				i == 1 ? TINV_PAGE_BASE : TINV_SINGLE_PAGE, v};
			@(posedge ref_clk_in);
			tlb_inv_in <= '0;
			#1 chk(tlb_inv_done_out, i == 0 ? 2'b10 : 2'b01);
			look(i != 2);
		end
		for (int o = 0; o < 3; o++)
			for (int m = 1; m < 4; m++) begin
				@(posedge ref_clk_in);
				slow <= $random(seed);
				mop(m[1:0], tsc_maint_op_t'(o));
			end
		wr(REG_T0_CTRL, 32'h0000_0040);
		wr(REG_T1_CTRL, 32'h0000_0020);
		local_irq_in0 <= 1'b1;
		local_irq_in1 <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		#1 chk(thread_irq_out, 4'b1001);
		for (int i = 0; i < 2; i++) begin
			a = $random(seed);
			@(posedge ref_clk_in);
			addr_bit_mask_in_n <= i[0];
			repeat (4) @(posedge ref_clk_in);
			mem_req_in <= '{1'b1, a};
			@(posedge ref_clk_in);
			mem_req_in <= '0;
			#1 chk(mem_req_out.addr, i ? a : a & ~(32'h1 << 20));
			chk(mem_req_out.valid, 1'b1);
		end
		@(posedge ref_clk_in);
		stop_clock_in_n <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		#1 chk({thread_stall_out, stop_grant_out, snoop_enable_out,
			thread_irq_out}, 8'b1111_0000);
		@(posedge ref_clk_in);
		stop_clock_in_n <= 1'b1;
		therm_trip_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		k = 0;
		repeat (8) begin
			@(posedge ref_clk_in);
			#1 k += core_clk_run_out;
		end
		chk(k, 4);
		chk(thread_stall_out, 2'b00);
		@(posedge ref_clk_in);
		cat_trip_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		cat_trip_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		#1 chk(thread_stall_out, 2'b11);
		chk(core_clk_run_out, 1'b0);
		complete_run;
	end
endmodule : tb_two_thread_shared_cache_tlb_control
